// >>> shared/local_bus_cfg.svh
// local bus port constants: widths, reset values, timing
// assumes inclusion by bare name from the package file; logic files use its macros without including it
`ifndef LOCAL_BUS_CFG_SVH
`define LOCAL_BUS_CFG_SVH
`define LB_ADDR_W 32
`define LB_REG_OFS_W 12
`define LB_CLK_MAX_MHZ 40
`define LB_ADDR_RST 32'h0000_0000
`define LB_OFS_RST 12'h000
`endif

// >>> shared/local_bus_pkg.sv
// local bus port types shared by both ends
// assumes local_bus_cfg.svh on the include path
`include "local_bus_cfg.svh"
package local_bus_pkg;
  typedef logic [`LB_ADDR_W-1:0] addr_t;
  typedef logic [`LB_REG_OFS_W-1:0] ofs_t;
  // bus mode chosen from straps at reset
  typedef enum logic [1:0] {
    mode_burst_lo_size_lo,
    mode_burst_lo_size_hi,
    mode_burst_hi_size_lo,
    mode_burst_hi_size_hi
  } bus_mode_e;
endpackage : local_bus_pkg

// >>> shared/local_bus_if.sv
// shared local bus wires between the bridge end and the far-side agent
// assumes testbench joins the two ends and supplies core_clk
`timescale 1ns/10ps
`default_nettype none
interface local_bus_if;
  import local_bus_pkg::*;
  // address bus, driven by the owner
  addr_t dev_addr_o;
  logic dev_addr_oe;
  addr_t agt_addr_o;
  logic agt_addr_oe;
  addr_t addr;
  // transfer start from the far agent
  logic transfer_start_n;
  // shared busy line, open-drain style
  logic dev_busy_o;
  logic dev_busy_oe;
  logic agt_busy_o;
  logic agt_busy_oe;
  logic bus_busy_n;
  // request and grant
  logic bus_request_n;
  logic bus_grant_n;
  // transfer error, either side may drive
  logic dev_terr_o;
  logic dev_terr_oe;
  logic agt_terr_o;
  logic agt_terr_oe;
  logic transfer_error_n;
  // reset straps
  logic burst_in_progress_strap;
  logic transfer_size_hi;
  logic master_enable_strap;
  // wire resolution, busy and error pulled high when nobody drives, address reads zero
  assign addr = dev_addr_oe ? dev_addr_o : (agt_addr_oe ? agt_addr_o : '0);
  assign bus_busy_n = (dev_busy_oe ? dev_busy_o : 1'b1) & (agt_busy_oe ? agt_busy_o : 1'b1);
  assign transfer_error_n = (dev_terr_oe ? dev_terr_o : 1'b1)
                          & (agt_terr_oe ? agt_terr_o : 1'b1);
  modport device (
    input addr, transfer_start_n, bus_busy_n, bus_grant_n, transfer_error_n,
    input burst_in_progress_strap, transfer_size_hi, master_enable_strap,
    output dev_addr_o, dev_addr_oe, dev_busy_o, dev_busy_oe, bus_request_n,
    output dev_terr_o, dev_terr_oe
  );
  modport agent (
    input addr, bus_busy_n, bus_request_n, transfer_error_n,
    output agt_addr_o, agt_addr_oe, transfer_start_n, agt_busy_o, agt_busy_oe,
    output bus_grant_n, agt_terr_o, agt_terr_oe,
    output burst_in_progress_strap, transfer_size_hi, master_enable_strap
  );
endinterface : local_bus_if
`default_nettype wire

// >>> logic/local_bus_agent.sv
// far-side agent: arbiter plus master that starts transfers into the bridge
// assumes core_clk is the local bus clock shared with the bridge end
`timescale 1ns/10ps
`default_nettype none
module local_bus_agent (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // user side
  input wire logic user_start,
  input wire local_bus_pkg::addr_t user_addr,
  input wire logic user_fail_next,
  input wire logic strap_burst,
  input wire logic strap_size_hi,
  input wire logic strap_master_en,
  output logic user_error_seen,
  // local bus
  local_bus_if.agent lb
);
  import local_bus_pkg::*;
  typedef enum logic [1:0] {a_idle, a_grant, a_start, a_end} agt_st_e;
  typedef struct packed {
    agt_st_e st;
    logic grant_n;
    logic busy_oe;
    logic busy_o;
    logic ts_n;
    logic addr_oe;
    addr_t addr;
    logic terr_oe;
    logic err_seen;
    logic bs;
    logic sh;
    logic me;
  } agt_s;
  agt_s cur_ff, nxt_cur;
  // ************************
  // arbitration and transfers
  // ************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.ts_n = 1'b1;
    nxt_cur.terr_oe = 1'b0;
    nxt_cur.err_seen = 1'b0;
    nxt_cur.bs = strap_burst;
    nxt_cur.sh = strap_size_hi;
    nxt_cur.me = strap_master_en;
    unique case (cur_ff.st)
      a_idle: begin
        nxt_cur.busy_oe = 1'b0;
        nxt_cur.addr_oe = 1'b0;
        if (!lb.bus_request_n) begin
          nxt_cur.grant_n = 1'b0;
          nxt_cur.st = a_grant;
        end else if (user_start && lb.bus_busy_n) begin
          nxt_cur.busy_oe = 1'b1;
          nxt_cur.busy_o = 1'b0;
          nxt_cur.addr_oe = 1'b1;
          nxt_cur.addr = user_addr;
          nxt_cur.ts_n = 1'b0;
          nxt_cur.st = a_start;
        end
      end
      a_grant: begin
        // request drops as the bridge takes the bus; error stands for its data edge
        if (lb.bus_request_n) begin
          nxt_cur.grant_n = 1'b1;
          nxt_cur.terr_oe = user_fail_next;
          nxt_cur.st = a_idle;
        end
      end
      a_start: begin
        nxt_cur.busy_o = 1'b1;
        nxt_cur.st = a_end;
      end
      a_end: begin
        nxt_cur.err_seen = !lb.transfer_error_n;
        nxt_cur.busy_oe = 1'b0;
        nxt_cur.addr_oe = 1'b0;
        nxt_cur.st = a_idle;
      end
    endcase
  end
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // straps keep flowing under reset so the bridge senses them at release
      cur_ff <= '{st: a_idle, grant_n: 1'b1, busy_oe: 1'b0, busy_o: 1'b1, ts_n: 1'b1,
                  addr_oe: 1'b0, addr: `LB_ADDR_RST, terr_oe: 1'b0, err_seen: 1'b0,
                  bs: strap_burst, sh: strap_size_hi, me: strap_master_en};
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  // pins
  assign lb.bus_grant_n = cur_ff.grant_n;
  assign lb.agt_busy_oe = cur_ff.busy_oe;
  assign lb.agt_busy_o = cur_ff.busy_o;
  assign lb.transfer_start_n = cur_ff.ts_n;
  assign lb.agt_addr_oe = cur_ff.addr_oe;
  assign lb.agt_addr_o = cur_ff.addr;
  assign lb.agt_terr_oe = cur_ff.terr_oe;
  assign lb.agt_terr_o = 1'b0;
  assign lb.burst_in_progress_strap = cur_ff.bs;
  assign lb.transfer_size_hi = cur_ff.sh;
  assign lb.master_enable_strap = cur_ff.me;
  assign user_error_seen = cur_ff.err_seen;
endmodule : local_bus_agent
`default_nettype wire

// >>> logic/local_bus_bridge.sv
// bridge end of the local bus port: address, error, arbitration, straps
// assumes every agent runs on core_clk as the local bus clock
`timescale 1ns/10ps
`default_nettype none
module local_bus_bridge (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // mode control
  input wire logic async_arb,
  // master requests from the core
  input wire logic mst_req,
  input wire local_bus_pkg::addr_t mst_addr,
  output logic mst_done,
  output logic mst_error,
  // slave side results
  input wire logic slv_fail,
  output logic slv_hit,
  output local_bus_pkg::addr_t slv_addr,
  output local_bus_pkg::ofs_t slv_reg_ofs,
  // reset-time results
  output local_bus_pkg::bus_mode_e bus_mode,
  output logic bus_master_enable,
  // local bus
  local_bus_if.device lb
);
  import local_bus_pkg::*;
  typedef enum logic [2:0] {m_idle, m_req, m_own, m_data, m_neg} mst_st_e;

  // ************************
  // state record
  // ************************
  typedef struct packed {
    // master sequencing and bus drives
    mst_st_e st;
    logic req_n; // bus request pin, low asks
    logic busy_oe; // busy wire driven by us
    logic busy_o;
    logic addr_oe; // address bus driven by us
    addr_t addr_o;
    // master results, one-cycle pulses
    logic done;
    logic err;
    // slave capture on the strobe edge
    logic hit;
    addr_t s_addr;
    ofs_t s_ofs;
    logic terr_oe; // error wire pulled low for one cycle
    // straps sensed around reset
    bus_mode_e mode;
    logic bme;
    logic in_rst; // high until the first edge after release
    // two-flop copies for asynchronous arbitration
    logic g1;
    logic g2;
    logic b1;
    logic b2;
  } brg_s;
  brg_s cur_ff, nxt_cur;
  logic grant_seen;
  logic busy_seen_n;
  // ************************
  // arbitration input select
  // ************************
  // async mode reads the two-flop copies, sync mode samples directly
  always_comb begin
    grant_seen = async_arb ? !cur_ff.g2 : !lb.bus_grant_n;
    busy_seen_n = async_arb ? cur_ff.b2 : lb.bus_busy_n;
  end
  // ************************
  // next state
  // ************************
  always_comb begin
    // hold everything unless a branch below changes it
    nxt_cur = cur_ff;

    // grant and busy enter a two-flop chain every cycle
    nxt_cur.g1 = lb.bus_grant_n;
    nxt_cur.g2 = cur_ff.g1;
    nxt_cur.b1 = lb.bus_busy_n;
    nxt_cur.b2 = cur_ff.b1;

    // pulses and the slave error drive last one cycle
    nxt_cur.done = 1'b0;
    nxt_cur.err = 1'b0;
    nxt_cur.hit = 1'b0;
    nxt_cur.terr_oe = 1'b0;
    nxt_cur.in_rst = 1'b0;

    // straps caught on the first edge after reset release
    if (cur_ff.in_rst) begin
      nxt_cur.mode = bus_mode_e'({lb.burst_in_progress_strap, lb.transfer_size_hi});
      nxt_cur.bme = lb.master_enable_strap;
    end

    // slave capture on the strobe edge, only while not owning
    // a strobe seen while we drive the address is our own cycle
    if (!lb.transfer_start_n && !cur_ff.addr_oe) begin
      nxt_cur.hit = 1'b1;
      nxt_cur.s_addr = lb.addr;
      nxt_cur.s_ofs = lb.addr[`LB_REG_OFS_W-1:0];
      nxt_cur.terr_oe = slv_fail;
    end

    // master sequence: request, own, data, release
    unique case (cur_ff.st)
      // take a core request and raise the bus request
      m_idle: begin
        if (mst_req) begin
          nxt_cur.req_n = 1'b0;
          nxt_cur.addr_o = mst_addr;
          nxt_cur.st = m_req;
        end
      end
      // wait for grant with the busy wire free
      m_req: begin
        if (grant_seen && busy_seen_n) begin
          nxt_cur.req_n = 1'b1;
          nxt_cur.busy_oe = 1'b1;
          nxt_cur.busy_o = 1'b0;
          nxt_cur.addr_oe = 1'b1;
          nxt_cur.st = m_own;
        end
      end
      // address phase, busy held low
      m_own: begin
        nxt_cur.st = m_data;
      end
      // sample the error wire, drive busy high before release
      m_data: begin
        nxt_cur.err = !lb.transfer_error_n;
        nxt_cur.done = 1'b1;
        nxt_cur.busy_o = 1'b1;
        nxt_cur.addr_oe = 1'b0;
        nxt_cur.st = m_neg;
      end
      // stop driving busy, back to idle
      m_neg: begin
        nxt_cur.busy_oe = 1'b0;
        nxt_cur.st = m_idle;
      end
      // unused codes fall back to idle
      default: nxt_cur.st = m_idle;
    endcase
  end
  // ************************
  // state register
  // ************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // idle, bus released, pins negated, straps pending
      cur_ff <= '{st: m_idle,
                  req_n: 1'b1,
                  busy_oe: 1'b0,
                  busy_o: 1'b1,
                  addr_oe: 1'b0,
                  addr_o: `LB_ADDR_RST,
                  done: 1'b0,
                  err: 1'b0,
                  hit: 1'b0,
                  s_addr: `LB_ADDR_RST,
                  s_ofs: `LB_OFS_RST,
                  terr_oe: 1'b0,
                  mode: mode_burst_lo_size_lo,
                  bme: 1'b0,
                  in_rst: 1'b1,
                  g1: 1'b1,
                  g2: 1'b1,
                  b1: 1'b1,
                  b2: 1'b1};
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  // ************************
  // outputs
  // ************************
  // bus wires
  assign lb.bus_request_n = cur_ff.req_n;
  assign lb.dev_busy_oe = cur_ff.busy_oe;
  assign lb.dev_busy_o = cur_ff.busy_o;
  assign lb.dev_addr_oe = cur_ff.addr_oe;
  assign lb.dev_addr_o = cur_ff.addr_o;
  assign lb.dev_terr_oe = cur_ff.terr_oe;
  assign lb.dev_terr_o = 1'b0;

  // master results
  assign mst_done = cur_ff.done;
  assign mst_error = cur_ff.err;

  // slave results
  assign slv_hit = cur_ff.hit;
  assign slv_addr = cur_ff.s_addr;
  assign slv_reg_ofs = cur_ff.s_ofs;

  // strap results
  assign bus_mode = cur_ff.mode;
  assign bus_master_enable = cur_ff.bme;
endmodule : local_bus_bridge
`default_nettype wire

// >>> bench/local_bus_checker.sv
// checker for the shared local bus wires between bridge and agent
// assumes instantiation beside local_bus_if, one clock core_clk
`timescale 1ns/10ps
`default_nettype none
module local_bus_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bridge drives
  input wire local_bus_pkg::addr_t dev_addr_o,
  input wire logic dev_addr_oe,
  input wire logic dev_busy_o,
  input wire logic dev_busy_oe,
  input wire logic dev_terr_o,
  input wire logic dev_terr_oe,
  input wire logic bus_request_n,
  // resolved wires
  input wire logic bus_grant_n,
  input wire logic bus_busy_n,
  input wire logic transfer_start_n
);
  import local_bus_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************
  // ownership and wire rules
  // ****************
  grant_taken_a: assert property ($rose(dev_busy_oe) |->
    $past(bus_grant_n) == 1'b0 && $past(bus_busy_n)) else $error("bus taken without grant");
  own_start_a: assert property ($rose(dev_addr_oe) |->
    $rose(bus_request_n) && dev_busy_oe && !dev_busy_o) else $error("bad ownership start");
  addr_window_a: assert property ($rose(dev_addr_oe) |->
    dev_addr_oe [*2] ##1 !dev_addr_oe) else $error("address drive length wrong");
  addr_steady_a: assert property (dev_addr_oe && $past(dev_addr_oe) |->
    $stable(dev_addr_o)) else $error("address moved mid cycle");
  busy_negate_a: assert property ($fell(dev_busy_oe) |-> $past(dev_busy_o))
    else $error("busy released while low");
  busy_release_a: assert property (dev_busy_oe && dev_busy_o |=> !dev_busy_oe)
    else $error("busy not released after negation");
  req_bound_a: assert property ($fell(bus_request_n) |-> ##[1:12] $rose(bus_request_n))
    else $error("request never released");
  slave_quiet_a: assert property (!transfer_start_n |-> !dev_addr_oe && !dev_busy_oe)
    else $error("bridge drives during foreign start");
  slave_err_a: assert property (dev_terr_oe && !dev_terr_o |->
    $past(transfer_start_n) == 1'b0) else $error("error without slave strobe");
  err_pulse_a: assert property (dev_terr_oe && !dev_terr_o |=>
    !(dev_terr_oe && !dev_terr_o)) else $error("slave error longer than one cycle");
endmodule : local_bus_checker
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench joining bridge and agent over the shared local bus
// assumes package, interface, design ends and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import local_bus_pkg::*;
  logic core_clk, rst, async_arb, mst_req, mst_done, mst_error, slv_fail, slv_hit;
  addr_t mst_addr, slv_addr, user_addr;
  ofs_t slv_reg_ofs;
  bus_mode_e bus_mode;
  logic bus_master_enable, user_start, user_fail_next, user_error_seen;
  logic strap_burst, strap_size_hi, strap_master_en;
  int miscompares, n_compared, s, k;
  addr_t addr_seen;
  logic hit_d;
  logic [32:0] q_m[$];
  logic [43:0] q_s[$];
  logic q_u[$];
  local_bus_if lb ();
  local_bus_bridge i_local_bus_bridge (.core_clk, .rst, .async_arb, .mst_req, .mst_addr,
    .mst_done, .mst_error, .slv_fail, .slv_hit, .slv_addr, .slv_reg_ofs, .bus_mode,
    .bus_master_enable, .lb);
  local_bus_agent i_local_bus_agent (.core_clk, .rst, .user_start, .user_addr,
    .user_fail_next, .strap_burst, .strap_size_hi, .strap_master_en, .user_error_seen, .lb);
  local_bus_checker i_checker (.core_clk, .rst, .dev_addr_o(lb.dev_addr_o),
    .dev_addr_oe(lb.dev_addr_oe), .dev_busy_o(lb.dev_busy_o), .dev_busy_oe(lb.dev_busy_oe),
    .dev_terr_o(lb.dev_terr_o), .dev_terr_oe(lb.dev_terr_oe), .bus_request_n(lb.bus_request_n),
    .bus_grant_n(lb.bus_grant_n), .bus_busy_n(lb.bus_busy_n),
    .transfer_start_n(lb.transfer_start_n));
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // one operation: bridge master, agent master into bridge, or both at once
  task automatic run_op(input int n);
    addr_t a;
    logic dm, ds, f, g;
    int i;
    a = (n == 0) ? 32'hFFFF_FFFF : addr_t'($urandom);
    dm = (n % 3 != 1);
    ds = (n % 3 != 0);
    f = dm & ~ds & 1'($urandom);
    g = ds & 1'($urandom);
    @(negedge core_clk);
    async_arb = (n % 3 == 0) && (n > 4);
    mst_req = dm;
    mst_addr = ~a;
    user_fail_next = f;
    user_start = ds;
    user_addr = a;
    slv_fail = g;
    if (dm) q_m.push_back({~a, f});
    if (ds) q_s.push_back({a, a[11:0]});
    if (ds) q_u.push_back(g);
    for (i = 0; i < 40 && (mst_req || user_start); i++) begin
      @(negedge core_clk);
      if (!lb.bus_request_n) mst_req = 1'b0;
      if (!lb.transfer_start_n) user_start = 1'b0;
    end
    for (i = 0; i < 40 && q_m.size() + q_s.size() + q_u.size() > 0; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask : run_op
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // result monitor against the noted expectations
  always @(posedge core_clk) begin
    // last address the bridge put on the bus, and slave hits one cycle back
    if (lb.dev_addr_oe) addr_seen <= lb.addr;
    hit_d <= !rst && slv_hit;
    if (!rst && mst_done) check(64'({addr_seen, mst_error}), 64'(q_m.pop_front()));
    if (!rst && slv_hit) check(64'({slv_addr, slv_reg_ofs}), 64'(q_s.pop_front()));
    if (!rst && (hit_d || user_error_seen)) begin
      check(64'({hit_d, user_error_seen}), 64'({1'b1, q_u.pop_front()}));
    end
  end
  // watchdog
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  // main sequence: strap modes under reset, then mixed traffic
  initial begin
    rst = 1'b1;
    {async_arb, mst_req, slv_fail, user_start, user_fail_next} = 5'h00;
    {strap_burst, strap_size_hi, strap_master_en} = 3'h0;
    mst_addr = '0;
    user_addr = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h8F5E));
    for (s = 0; s < 4; s++) begin
      rst = 1'b1;
      {strap_burst, strap_size_hi} = 2'(s);
      strap_master_en = ^2'(s);
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(negedge core_clk);
      check(64'(bus_mode), 64'(s));
      check(64'(bus_master_enable), 64'(strap_master_en));
    end
    for (k = 0; k < 12; k++) run_op(k);
    check(64'(q_m.size() + q_s.size() + q_u.size()), 64'h0);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
